// >>> hw/spf_defs.svh
`ifndef SPF_DEFS_SVH
`define SPF_DEFS_SVH

`define SPF_NPORT          4
`define SPF_LAST_PORT      2'h3
`define SPF_BUF_DEPTH      256
`define SPF_CNT_W          9
`define SPF_BUF_LAST       9'h0ff
`define SPF_ADDR_W         6
`define SPF_PORT_MSB       5
`define SPF_PORT_LSB       4
`define SPF_REG_MSB        3

`define SPF_REG_RX_START   4'h0
`define SPF_REG_RX_END     4'h1
`define SPF_REG_TX_START   4'h2
`define SPF_REG_TX_END1    4'h3
`define SPF_REG_TX_END2    4'h4
`define SPF_REG_ERR_CHAR   4'h5
`define SPF_REG_PROTOCOL   4'h6
`define SPF_REG_PARITY     4'h7
`define SPF_REG_CTRL       4'h8
`define SPF_REG_STATUS     4'h9
`define SPF_REG_RX_COUNT   4'ha
`define SPF_REG_RX_DATA    4'hb

`define SPF_CTRL_BLOCK_OUT 0
`define SPF_ST_READY       0
`define SPF_ST_BAD_PROTO   1
`define SPF_ST_HUNTING     2
`define SPF_ST_FULL        3

`define SPF_CHAR_NONE      8'h00
`define SPF_CHAR_MSB       7
`define SPF_CODE_CRLF      8'h80
`define SPF_CODE_CR        8'h0d
`define SPF_CODE_LF        8'h0a
`define SPF_TX_END1_RST    8'h80
`define SPF_TX_END1_RST_P3 8'h00
`define SPF_DEFAULT_ZERO   8'h00

`define SPF_PAR_EVEN       8'h02
`define SPF_PAR_ODD        8'h03
`define SPF_PAR_NONE       8'h04

`define SPF_PROTO_NORMAL   8'h00
`define SPF_PROTO_POLL_M   8'h01
`define SPF_PROTO_POLL_S   8'h02
`define SPF_PROTO_SORTER   8'h03
`define SPF_PROTO_CHAIN_M  8'h04
`define SPF_PROTO_SAME_S   8'h05
`define SPF_PROTO_SPLIT_S  8'h06
`define SPF_PROTO_TUNNEL   8'h07
`define SPF_PROTO_HEIGHT   8'h08
`define SPF_PROTO_EXTDATA  8'h09
`define SPF_PROTO_REDIRECT 8'h0a

`endif

// >>> hw/spf_pkg.sv
`include "spf_defs.svh"

package spf_pkg;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       par_bit;
    logic       frame_err;
  } spf_rx_char_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
  } spf_tx_src_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } spf_line_t;

  typedef struct packed {
    logic [10:0] mode;
    logic        invalid;
    logic        fwd_same;
    logic        fwd_alt;
    logic        to_net;
    logic        merge;
    logic [1:0]  dest;
  } spf_route_t;

  typedef enum logic [2:0] {
    SPF_RX_HUNT    = 3'b001,
    SPF_RX_COLLECT = 3'b010,
    SPF_RX_DONE    = 3'b100
  } spf_rx_state_t;

  typedef enum logic [5:0] {
    SPF_TX_IDLE    = 6'b000001,
    SPF_TX_PRE     = 6'b000010,
    SPF_TX_DATA    = 6'b000100,
    SPF_TX_END1    = 6'b001000,
    SPF_TX_END1_LF = 6'b010000,
    SPF_TX_END2    = 6'b100000
  } spf_tx_state_t;

endpackage : spf_pkg

// >>> hw/spf_framer.sv
`timescale 1ns/1ns
`include "spf_defs.svh"

module spf_framer (
  input  wire logic                    clk_sys_in,
  input  wire logic                    nrst_in,
  input  wire logic                    ce_in,
  input  wire logic [`SPF_ADDR_W-1:0]  reg_addr_in,
  input  wire logic [7:0]              reg_wdata_in,
  input  wire logic                    reg_wr_in,
  input  wire logic                    reg_rd_in,
  output logic [7:0]                   reg_rdata_out,
  input  spf_pkg::spf_rx_char_t        rx_char_in [`SPF_NPORT],
  input  spf_pkg::spf_tx_src_t         tx_src_in [`SPF_NPORT],
  output logic [`SPF_NPORT-1:0]        tx_src_ready_out,
  output spf_pkg::spf_line_t           tx_line_out [`SPF_NPORT],
  input  wire logic [`SPF_NPORT-1:0]   tx_line_ready_in,
  output spf_pkg::spf_route_t          route_out [`SPF_NPORT]
);
  import spf_pkg::*;

  logic [7:0] rd_val [`SPF_NPORT];
  logic [1:0] port_sel;
  logic [3:0] reg_sel;

  assign port_sel = reg_addr_in[`SPF_PORT_MSB:`SPF_PORT_LSB];
  assign reg_sel  = reg_addr_in[`SPF_REG_MSB:0];

  // Read data lives only in the cycle after the strobe
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
      reg_rdata_out <= `SPF_DEFAULT_ZERO;
    else if (ce_in)
      reg_rdata_out <= reg_rd_in ? rd_val[port_sel] : `SPF_DEFAULT_ZERO;
  end

  for (genvar p = 0; p < `SPF_NPORT; p++)
  begin : g_port
    logic                  sel;
    logic                  wr;
    logic                  pop;
    logic [7:0]            rx_start_q;
    logic [7:0]            rx_end_char_q;
    logic [7:0]            tx_start_q;
    logic [7:0]            tx_end_char_first_q;
    logic [7:0]            tx_end_char_second_q;
    logic [7:0]            err_char_q;
    logic [7:0]            proto_q;
    logic [7:0]            parity_q;
    logic                  block_out_q;
    spf_rx_state_t         rx_state_q;
    spf_rx_state_t         rx_idle;
    logic [`SPF_CNT_W-1:0] cnt_q;
    logic [7:0]            rd_ptr_q;
    logic [7:0]            prev_q;
    logic [7:0]            mem_q [`SPF_BUF_DEPTH];
    logic                  ones;
    logic                  par_err;
    logic                  subst_en;
    logic [7:0]            ch;
    logic                  term_hit;
    logic                  at_last;
    logic                  store;
    logic [7:0]            store_val;
    logic                  drained;
    spf_tx_state_t         tx_state_q;
    spf_tx_state_t         after_data;
    spf_tx_state_t         after_end1;
    logic                  slot_free;
    spf_route_t            route_d;

    assign sel = (port_sel == 2'(p));
    assign wr  = ce_in && reg_wr_in && sel;
    assign pop = ce_in && reg_rd_in && sel
                 && (reg_sel == `SPF_REG_RX_DATA)
                 && (rx_state_q == SPF_RX_DONE);

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
      if (!nrst_in)
      begin
        rx_start_q           <= `SPF_DEFAULT_ZERO;
        rx_end_char_q        <= `SPF_DEFAULT_ZERO;
        tx_start_q           <= `SPF_DEFAULT_ZERO;
        tx_end_char_first_q  <= (p == `SPF_NPORT - 1) ?
                                `SPF_TX_END1_RST_P3 : `SPF_TX_END1_RST;
        tx_end_char_second_q <= `SPF_DEFAULT_ZERO;
        err_char_q           <= `SPF_DEFAULT_ZERO;
        proto_q              <= `SPF_PROTO_NORMAL;
        parity_q             <= `SPF_PAR_NONE;
        block_out_q          <= 1'b0;
      end
      else if (wr)
      begin
        unique case (reg_sel)
          `SPF_REG_RX_START: rx_start_q           <= reg_wdata_in;
          `SPF_REG_RX_END:   rx_end_char_q        <= reg_wdata_in;
          `SPF_REG_TX_START: tx_start_q           <= reg_wdata_in;
          `SPF_REG_TX_END1:  tx_end_char_first_q  <= reg_wdata_in;
          `SPF_REG_TX_END2:  tx_end_char_second_q <= reg_wdata_in;
          `SPF_REG_ERR_CHAR: err_char_q           <= reg_wdata_in;
          `SPF_REG_PROTOCOL: proto_q              <= reg_wdata_in;
          `SPF_REG_PARITY:   parity_q             <= reg_wdata_in;
          `SPF_REG_CTRL:     block_out_q <= reg_wdata_in[`SPF_CTRL_BLOCK_OUT];
          default:           ;
        endcase
      end
    end

    // Receive character conditioning
    assign ones     = ^{rx_char_in[p].data, rx_char_in[p].par_bit};
    assign par_err  = ((parity_q == `SPF_PAR_EVEN) && ones)
                      || ((parity_q == `SPF_PAR_ODD) && !ones);
    assign subst_en = !err_char_q[`SPF_CHAR_MSB];
    assign ch       = ((par_err || rx_char_in[p].frame_err) && subst_en) ?
                      err_char_q : rx_char_in[p].data;

    // A two-character terminator takes precedence over the single one
    always_comb
    begin
      if (tx_end_char_second_q != `SPF_CHAR_NONE)
        term_hit = (prev_q == tx_end_char_first_q)
                   && (ch == tx_end_char_second_q);
      else
        term_hit = (rx_end_char_q[6:0] != 7'h00)
                   && (ch == {1'b0, rx_end_char_q[6:0]});
    end

    assign rx_idle = (rx_start_q != `SPF_CHAR_NONE) ?
                     SPF_RX_HUNT : SPF_RX_COLLECT;
    assign at_last = (cnt_q == `SPF_BUF_LAST);
    assign store   = ce_in && rx_char_in[p].valid
                     && (rx_state_q == SPF_RX_COLLECT)
                     && (!term_hit || rx_end_char_q[`SPF_CHAR_MSB]);
    // Last slot carries the error character, unless its bit 7 is set, so software sees the cut
    assign store_val = (at_last && !term_hit && subst_en) ?
                       err_char_q : ch;
    assign drained   = ({1'b0, rd_ptr_q} + 9'h001) >= cnt_q;

    always_ff @(posedge clk_sys_in)
    begin
      if (store)
        mem_q[cnt_q[7:0]] <= store_val;
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
      if (!nrst_in)
      begin
        rx_state_q <= SPF_RX_COLLECT;
        cnt_q      <= '0;
        rd_ptr_q   <= 8'h00;
        prev_q     <= `SPF_CHAR_NONE;
      end
      else if (ce_in)
      begin
        unique case (rx_state_q)
          SPF_RX_HUNT:
          begin
            // Start character is consumed, never stored
            if (rx_char_in[p].valid && rx_char_in[p].data == rx_start_q)
              rx_state_q <= SPF_RX_COLLECT;
          end
          SPF_RX_COLLECT:
          begin
            if (rx_char_in[p].valid)
            begin
              prev_q <= ch;
              if (store)
                cnt_q <= cnt_q + 9'h001;
              if (term_hit || at_last)
                rx_state_q <= SPF_RX_DONE;
            end
          end
          SPF_RX_DONE:
          begin
            // Arrivals are dropped until software has emptied the block
            if (pop)
            begin
              rd_ptr_q <= rd_ptr_q + 8'h01;
              if (drained)
              begin
                rx_state_q <= rx_idle;
                cnt_q      <= '0;
                rd_ptr_q   <= 8'h00;
                prev_q     <= `SPF_CHAR_NONE;
              end
            end
          end
          default: rx_state_q <= SPF_RX_COLLECT;
        endcase
        // New start character drops a partial block so the hunt rearms
        if (wr && (reg_sel == `SPF_REG_RX_START)
            && (rx_state_q != SPF_RX_DONE))
        begin
          rx_state_q <= (reg_wdata_in != `SPF_CHAR_NONE) ?
                        SPF_RX_HUNT : SPF_RX_COLLECT;
          cnt_q      <= '0;
          prev_q     <= `SPF_CHAR_NONE;
        end
      end
    end

    // Transmit framing
    assign slot_free = !tx_line_out[p].valid || tx_line_ready_in[p];
    assign tx_src_ready_out[p] = slot_free && (tx_state_q == SPF_TX_DATA);

    always_comb
    begin
      if (block_out_q && tx_end_char_second_q != `SPF_CHAR_NONE)
        after_end1 = SPF_TX_END2;
      else
        after_end1 = SPF_TX_IDLE;
      if (tx_end_char_first_q != `SPF_CHAR_NONE)
        after_data = SPF_TX_END1;
      else
        after_data = after_end1;
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
      if (!nrst_in)
      begin
        tx_state_q        <= SPF_TX_IDLE;
        tx_line_out[p]    <= '0;
      end
      else if (ce_in)
      begin
        if (tx_line_ready_in[p])
          tx_line_out[p].valid <= 1'b0;
        if (slot_free)
        begin
          unique case (tx_state_q)
            SPF_TX_IDLE:
            begin
              if (tx_src_in[p].valid)
                tx_state_q <= (tx_start_q != `SPF_CHAR_NONE) ?
                              SPF_TX_PRE : SPF_TX_DATA;
            end
            SPF_TX_PRE:
            begin
              tx_line_out[p] <= '{valid: 1'b1, data: tx_start_q};
              tx_state_q     <= SPF_TX_DATA;
            end
            SPF_TX_DATA:
            begin
              if (tx_src_in[p].valid)
              begin
                tx_line_out[p] <= '{valid: 1'b1, data: tx_src_in[p].data};
                if (tx_src_in[p].last)
                  tx_state_q <= after_data;
              end
            end
            SPF_TX_END1:
            begin
              // Code 128 stands for the CR LF pair
              if (tx_end_char_first_q == `SPF_CODE_CRLF)
              begin
                tx_line_out[p] <= '{valid: 1'b1, data: `SPF_CODE_CR};
                tx_state_q     <= SPF_TX_END1_LF;
              end
              else
              begin
                tx_line_out[p] <= '{valid: 1'b1,
                                    data: tx_end_char_first_q};
                tx_state_q     <= after_end1;
              end
            end
            SPF_TX_END1_LF:
            begin
              tx_line_out[p] <= '{valid: 1'b1, data: `SPF_CODE_LF};
              tx_state_q     <= after_end1;
            end
            SPF_TX_END2:
            begin
              tx_line_out[p] <= '{valid: 1'b1,
                                  data: tx_end_char_second_q};
              tx_state_q     <= SPF_TX_IDLE;
            end
            default: tx_state_q <= SPF_TX_IDLE;
          endcase
        end
      end
    end

    // Protocol decode and routing of delivered blocks
    always_comb
    begin
      route_d         = '0;
      route_d.dest    = 2'(p);
      route_d.invalid = (proto_q == `SPF_PROTO_TUNNEL)
                        || (proto_q > `SPF_PROTO_REDIRECT);
      if (!route_d.invalid)
        route_d.mode[proto_q[3:0]] = 1'b1;
      route_d.merge    = (proto_q == `SPF_PROTO_CHAIN_M);
      route_d.fwd_same = (proto_q == `SPF_PROTO_SAME_S);
      route_d.fwd_alt  = (proto_q == `SPF_PROTO_SPLIT_S);
      route_d.to_net   = (proto_q == `SPF_PROTO_REDIRECT);
      // Host pairs with terminal, setup with the fourth port
      if (route_d.fwd_alt)
        route_d.dest = 2'(p) ^ 2'h1;
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
      if (!nrst_in)
        route_out[p] <= '0;
      else if (ce_in)
        route_out[p] <= route_d;
    end

    always_comb
    begin
      rd_val[p] = `SPF_DEFAULT_ZERO;
      unique case (reg_sel)
        `SPF_REG_RX_START: rd_val[p] = rx_start_q;
        `SPF_REG_RX_END:   rd_val[p] = rx_end_char_q;
        `SPF_REG_TX_START: rd_val[p] = tx_start_q;
        `SPF_REG_TX_END1:  rd_val[p] = tx_end_char_first_q;
        `SPF_REG_TX_END2:  rd_val[p] = tx_end_char_second_q;
        `SPF_REG_ERR_CHAR: rd_val[p] = err_char_q;
        `SPF_REG_PROTOCOL: rd_val[p] = proto_q;
        `SPF_REG_PARITY:   rd_val[p] = parity_q;
        `SPF_REG_CTRL:
          rd_val[p][`SPF_CTRL_BLOCK_OUT] = block_out_q;
        `SPF_REG_STATUS:
        begin
          rd_val[p][`SPF_ST_READY]     = (rx_state_q == SPF_RX_DONE);
          rd_val[p][`SPF_ST_BAD_PROTO] = route_d.invalid;
          rd_val[p][`SPF_ST_HUNTING]   = (rx_state_q == SPF_RX_HUNT);
          rd_val[p][`SPF_ST_FULL]      = cnt_q[8];
        end
        `SPF_REG_RX_COUNT: rd_val[p] = cnt_q[7:0];
        `SPF_REG_RX_DATA:
          if (rx_state_q == SPF_RX_DONE)
            rd_val[p] = mem_q[rd_ptr_q];
        default:           ;
      endcase
    end
  end

endmodule : spf_framer

// >>> test/spf_line_model.sv
`timescale 1ns/1ns
`include "spf_defs.svh"
module spf_line_model (
  input  wire logic               clk_sys_in,
  input  spf_pkg::spf_line_t      tx_line_in [`SPF_NPORT],
  output logic [`SPF_NPORT-1:0]   ready_out,
  output spf_pkg::spf_rx_char_t   rx_out [`SPF_NPORT]
);
  import spf_pkg::*;
  logic [7:0] got_q [`SPF_NPORT][$];
  logic [1:0] cnt_q = 2'h0;
  initial
  begin
    ready_out = '0;
    for (int i = 0; i < `SPF_NPORT; i++)
      rx_out[i] = '0;
  end
  // Line stalls one cycle in four so held characters are exercised
  always @(posedge clk_sys_in)
  begin
    cnt_q <= cnt_q + 2'h1;
    ready_out <= {`SPF_NPORT{cnt_q != 2'h0}};
    for (int i = 0; i < `SPF_NPORT; i++)
      if (tx_line_in[i].valid && ready_out[i])
        got_q[i].push_back(tx_line_in[i].data);
  end
  // Released line shows inverted data so stale values never match
  task automatic put(int p, logic [7:0] d, logic par, logic fe);
    @(posedge clk_sys_in);
    rx_out[p] <= '{1'b1, d, par, fe};
    @(posedge clk_sys_in);
    rx_out[p] <= '{1'b0, ~d, ~par, 1'b0};
  endtask : put
endmodule : spf_line_model

// >>> test/spf_framer_chk.sv
`timescale 1ns/1ns
`include "spf_defs.svh"
module spf_framer_chk (
  input  wire logic                    clk_sys_in,
  input  wire logic                    nrst_in,
  input  wire logic                    ce_in,
  input  wire logic [`SPF_ADDR_W-1:0]  reg_addr_in,
  input  wire logic [7:0]              reg_wdata_in,
  input  wire logic                    reg_wr_in,
  input  wire logic                    reg_rd_in,
  input  wire logic [7:0]              reg_rdata_out,
  input  spf_pkg::spf_line_t           tx_line_out [`SPF_NPORT],
  input  wire logic [`SPF_NPORT-1:0]   tx_line_ready_in,
  input  spf_pkg::spf_route_t          route_out [`SPF_NPORT]
);
  import spf_pkg::*;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  wire pw = ce_in && reg_wr_in && reg_addr_in == 6'h06;
  property p_code(c, f);
    pw && reg_wdata_in == c |-> ##2 f;
  endproperty
  chk_line_hold: assert property (tx_line_out[2].valid
    && !tx_line_ready_in[2] && ce_in
    |=> tx_line_out[2].valid && $stable(tx_line_out[2].data))
    else $error("line char dropped under stall");
  chk_proto_bad: assert property (p_code(8'h07,
    route_out[0].invalid)) else $error("code 07 not invalid");
  chk_proto_mode: assert property (pw && reg_wdata_in <= 8'h0a
    && reg_wdata_in != 8'h07 |-> ##2 !route_out[0].invalid
    && route_out[0].mode == (11'h1 << $past(reg_wdata_in[3:0], 2)))
    else $error("protocol decode wrong");
  chk_chain_merge: assert property (p_code(8'h04,
    route_out[0].merge)) else $error("chain master no merge");
  chk_same_fwd: assert property (p_code(8'h05,
    route_out[0].fwd_same)) else $error("same port slave no fwd");
  chk_split_fwd: assert property (p_code(8'h06,
    route_out[0].fwd_alt && route_out[0].dest == 2'h1))
    else $error("split slave routing wrong");
  chk_net_route: assert property (p_code(8'h0a,
    route_out[0].to_net)) else $error("redirect not to network");
  chk_port_apart: assert property (pw |=>
    $stable(route_out[1])) else $error("other port route changed");
  cover property (pw && reg_wdata_in == 8'h07);
  cover property (tx_line_out[2].valid && !tx_line_ready_in[2]);
  cover property (ce_in && reg_rd_in);
endmodule : spf_framer_chk
bind spf_framer spf_framer_chk u_chk (.clk_sys_in, .nrst_in, .ce_in,
  .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
  .tx_line_out, .tx_line_ready_in, .route_out);

// >>> test/spf_framer_tb.sv
`timescale 1ns/1ns
`include "spf_defs.svh"
module spf_framer_tb;
  import spf_pkg::*;
  logic           clk_sys_in = 1'b0;
  logic           nrst_in = 1'b0;
  logic [5:0]     addr_q = 6'h00;
  logic [7:0]     wdata_q = 8'h00;
  logic           wr_q = 1'b0;
  logic           rd_q = 1'b0;
  logic [7:0]     rdata;
  logic [3:0]     src_rdy;
  logic [3:0]     line_rdy;
  spf_rx_char_t   rx_c [4];
  spf_tx_src_t    src_q [4];
  spf_line_t      line [4];
  spf_route_t     route [4];
  int             fail_count = 0;
  int             checked = 0;
  int             cyc = 0;
  initial
    for (int i = 0; i < 4; i++)
      src_q[i] = '0;
  always #5 clk_sys_in = ~clk_sys_in;
  spf_framer u_dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .ce_in(1'b1), .reg_addr_in(addr_q), .reg_wdata_in(wdata_q),
    .reg_wr_in(wr_q), .reg_rd_in(rd_q), .reg_rdata_out(rdata),
    .rx_char_in(rx_c), .tx_src_in(src_q), .tx_src_ready_out(src_rdy),
    .tx_line_out(line), .tx_line_ready_in(line_rdy), .route_out(route));
  spf_line_model u_line (.clk_sys_in(clk_sys_in), .tx_line_in(line),
    .ready_out(line_rdy), .rx_out(rx_c));
  function automatic logic [5:0] ad(logic [1:0] p, logic [3:0] i);
    return {p, i};
  endfunction : ad
  task automatic end_sim;
    $display("Checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim
  task automatic chk(logic [10:0] got, logic [10:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(logic [5:0] a, logic [7:0] d);
    @(posedge clk_sys_in);
    addr_q <= a;
    wdata_q <= d;
    wr_q <= 1'b1;
    @(posedge clk_sys_in);
    wr_q <= 1'b0;
  endtask : wr
  task automatic rdc(logic [5:0] a, logic [7:0] e);
    @(posedge clk_sys_in);
    addr_q <= a;
    rd_q <= 1'b1;
    @(posedge clk_sys_in);
    rd_q <= 1'b0;
    @(negedge clk_sys_in);
    chk(11'(rdata), 11'(e));
  endtask : rdc
  task automatic rx(int p, logic [7:0] d, logic bp, logic fe);
    u_line.put(p, d, ^d ^ bp, fe);
  endtask : rx
  task automatic rxs(int p, logic [7:0] d [$]);
    foreach (d[i])
      rx(p, d[i], 1'b0, 1'b0);
  endtask : rxs
  // Pops a whole block; a count of 256 wraps to zero in eight bits
  task automatic pops(int p, logic [7:0] e [$]);
    rdc(ad(2'(p), `SPF_REG_RX_COUNT), 8'(e.size()));
    foreach (e[i])
      rdc(ad(2'(p), `SPF_REG_RX_DATA), e[i]);
  endtask : pops
  task automatic txb(int p, logic [7:0] d [$]);
    foreach (d[i])
    begin
      @(posedge clk_sys_in);
      src_q[p] <= '{1'b1, d[i], i == d.size() - 1};
      @(negedge clk_sys_in);
      while (!src_rdy[p])
        @(negedge clk_sys_in);
    end
    @(posedge clk_sys_in);
    src_q[p] <= '0;
  endtask : txb
  task automatic qchk(int p, logic [7:0] e [$]);
    for (int n = 0; n < 80 && u_line.got_q[p].size() < e.size(); n++)
      @(posedge clk_sys_in);
    repeat (8) @(posedge clk_sys_in);
    chk(11'(u_line.got_q[p].size()), 11'(e.size()));
    foreach (e[i])
      chk(11'(u_line.got_q[p][i]), 11'(e[i]));
  endtask : qchk
  always @(posedge clk_sys_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      fail_count++;
      end_sim();
    end
  end
  initial
  begin
    repeat (5) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    for (int p = 0; p < 4; p++)
    begin
      rdc(ad(2'(p), `SPF_REG_TX_END1), p == 3 ? 8'h00 : 8'h80);
      rdc(ad(2'(p), `SPF_REG_PARITY), 8'h04);
    end
    wr(ad(0, 4'hc), 8'h55);
    rdc(ad(0, 4'hc), 8'h00);
    $display("Test reset values done");
    wr(ad(0, `SPF_REG_RX_START), 8'h02);
    wr(ad(0, `SPF_REG_RX_END), 8'h0d);
    rxs(0, '{8'h58, 8'h02, 8'h41, 8'h42, 8'h0d});
    rdc(ad(0, `SPF_REG_STATUS), 8'h01);
    pops(0, '{8'h41, 8'h42});
    rdc(ad(0, `SPF_REG_STATUS), 8'h04);
    wr(ad(0, `SPF_REG_RX_END), 8'h8d);
    rxs(0, '{8'h51, 8'h02, 8'h43, 8'h0d});
    pops(0, '{8'h43, 8'h0d});
    $display("Test receive framing done");
    wr(ad(0, `SPF_REG_PARITY), 8'h02);
    wr(ad(0, `SPF_REG_ERR_CHAR), 8'h3f);
    rx(0, 8'h02, 1'b0, 1'b0);
    rx(0, 8'h41, 1'b1, 1'b0);
    rx(0, 8'h42, 1'b0, 1'b1);
    rxs(0, '{8'h43, 8'h0d});
    pops(0, '{8'h3f, 8'h3f, 8'h43, 8'h0d});
    wr(ad(0, `SPF_REG_ERR_CHAR), 8'h80);
    rx(0, 8'h02, 1'b0, 1'b0);
    rx(0, 8'h41, 1'b1, 1'b0);
    rx(0, 8'h0d, 1'b0, 1'b0);
    pops(0, '{8'h41, 8'h0d});
    $display("Test error substitution done");
    wr(ad(3, `SPF_REG_RX_END), 8'h0d);
    wr(ad(3, `SPF_REG_ERR_CHAR), 8'h3f);
    repeat (256)
      rx(3, 8'h41, 1'b0, 1'b0);
    rdc(ad(3, `SPF_REG_STATUS), 8'h09);
    rdc(ad(3, `SPF_REG_RX_COUNT), 8'h00);
    for (int i = 0; i < 256; i++)
      rdc(ad(3, `SPF_REG_RX_DATA), i == 255 ? 8'h3f : 8'h41);
    $display("Test full buffer done");
    wr(ad(1, `SPF_REG_TX_END1), 8'h0d);
    wr(ad(1, `SPF_REG_TX_END2), 8'h0a);
    wr(ad(1, `SPF_REG_RX_END), 8'h8a);
    rxs(1, '{8'h41, 8'h0a, 8'h42, 8'h0d, 8'h0a});
    pops(1, '{8'h41, 8'h0a, 8'h42, 8'h0d, 8'h0a});
    $display("Test paired terminator done");
    wr(ad(2, `SPF_REG_TX_START), 8'h02);
    wr(ad(2, `SPF_REG_TX_END2), 8'h03);
    wr(ad(2, `SPF_REG_CTRL), 8'h01);
    txb(2, '{8'h48, 8'h49});
    qchk(2, '{8'h02, 8'h48, 8'h49, 8'h0d, 8'h0a, 8'h03});
    txb(3, '{8'h5a});
    qchk(3, '{8'h5a});
    txb(1, '{8'h31});
    qchk(1, '{8'h31, 8'h0d});
    $display("Test transmit framing done");
    for (int c = 0; c <= 10; c++)
    begin
      wr(ad(0, `SPF_REG_PROTOCOL), 8'(c));
      // Route is registered from the setting, so it lags by one cycle
      repeat (2) @(negedge clk_sys_in);
      chk(route[0].mode, c == 7 ? 11'h000 : 11'h1 << c);
      chk(11'(route[0].invalid), 11'(c == 7));
      rdc(ad(0, `SPF_REG_STATUS), c == 7 ? 8'h06 : 8'h04);
    end
    chk(route[1].mode, 11'h001);
    $display("Test protocol decode done");
    end_sim();
  end
endmodule : spf_framer_tb
